// >>> design/sram_port_regs.svh
// Constants of the synchronous burst SRAM port
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// Array geometry: 512K words of four 9-bit lanes
`define SRAM_ADDR_W      19
`define SRAM_DEPTH       524288
`define SRAM_DATA_W      32
`define SRAM_LANES       4
`define SRAM_LANE_W      8
`define SRAM_WORD_W      36
`define SRAM_BURST_W     2

// Write path buffering
`define SRAM_FIFO_DEPTH  32
`define SRAM_FIFO_W      59

// Reset values
`define SRAM_DATA_RST    36'h0_0000_0000
`define SRAM_BURST_RST   2'h0
`define SRAM_ADDR_RST    19'h0_0000

`endif

// >>> design/sram_port_pkg.sv
// Types shared by the burst SRAM port
package sram_port_pkg;

    // Kind of access in effect after the last qualified edge
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE
    } access_t;

    // Burst order picked by the strap
    typedef enum logic {
        ORDER_LINEAR,
        ORDER_INTERLEAVED
    } burst_order_t;

endpackage

// >>> design/sync_fifo.sv
// Synchronous FIFO with valid and ready on both sides
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Depth is a power of two, so the pointers wrap by themselves
    always_comb
    begin
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next  = count_reg;
        if (push && !pop)
            count_next = count_reg + 1'b1;
        else if (pop && !push)
            count_next = count_reg - 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data_i;
    end

endmodule

// >>> design/sync_burst_sram_port.sv
// Flow-through burst SRAM port: control, burst counter, array
`include "sram_port_regs.svh"
module sync_burst_sram_port (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Address and control, synchronous to clk_i
    input  wire logic [`SRAM_ADDR_W-1:0]  address_i,
    input  wire logic                     write_strobe_n_i,
    input  wire logic [`SRAM_LANES-1:0]   byte_write_n_i,
    input  wire logic                     advance_load_n_i,
    input  wire logic                     chip_select1_n_i,
    input  wire logic                     chip_select2_i,
    input  wire logic                     chip_select3_n_i,
    input  wire logic                     clock_qualify_n_i,
    // Asynchronous controls and strap
    input  wire logic                     output_enable_n_i,
    input  wire logic                     sleep_request_i,
    input  wire logic                     burst_mode_i,
    // Data pins, split into input, output and enable
    input  wire logic [`SRAM_DATA_W-1:0]  data_i,
    input  wire logic [`SRAM_LANES-1:0]   parity_lines_i,
    output logic [`SRAM_DATA_W-1:0]       data_o,
    output logic [`SRAM_LANES-1:0]        parity_lines_o,
    output logic                          data_oe_n_o,
    // Write buffer status
    output logic                          write_ready_o
);

    ////////////////////////////////////////////////////////////////////////
    // Burst address arithmetic

    function automatic logic [`SRAM_ADDR_W-1:0] burst_index(
        input logic [`SRAM_ADDR_W-1:0]   base,
        input logic [`SRAM_BURST_W-1:0]  count,
        input sram_port_pkg::burst_order_t order
    );
        logic [`SRAM_BURST_W-1:0] low;
        low = (order == sram_port_pkg::ORDER_LINEAR)
            ? base[`SRAM_BURST_W-1:0] + count
            : base[`SRAM_BURST_W-1:0] ^ count;
        return {base[`SRAM_ADDR_W-1:`SRAM_BURST_W], low};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [`SRAM_WORD_W-1:0]      mem_reg [`SRAM_DEPTH];
    sram_port_pkg::access_t       access_reg;
    sram_port_pkg::access_t       access_next;
    sram_port_pkg::burst_order_t  order_reg;
    sram_port_pkg::burst_order_t  order_next;
    logic [`SRAM_ADDR_W-1:0]      base_reg;
    logic [`SRAM_ADDR_W-1:0]      base_next;
    logic [`SRAM_BURST_W-1:0]     count_reg;
    logic [`SRAM_BURST_W-1:0]     count_next;
    logic                         drive_reg;
    logic                         drive_next;
    logic [`SRAM_WORD_W-1:0]      read_reg;
    logic [`SRAM_WORD_W-1:0]      read_next;
    logic                         sleep_s1_reg;
    logic                         sleep_s2_reg;
    logic                         sleep_s3_reg;
    logic                         sleep_reg;
    logic                         sleep_next;

    logic                         qualified;
    logic                         selected;
    logic                         push_valid;
    logic [`SRAM_FIFO_W-1:0]      push_data;
    logic                         drain_valid;
    logic                         drain_ready;
    logic [`SRAM_FIFO_W-1:0]      drain_data;
    logic [`SRAM_ADDR_W-1:0]      drain_addr;
    logic [`SRAM_LANES-1:0]       drain_mask_n;
    logic [`SRAM_WORD_W-1:0]      drain_word;

    ////////////////////////////////////////////////////////////////////////
    // Sleep synchroniser: three stages, change taken once two agree

    always_comb
    begin
        sleep_next = (sleep_s2_reg == sleep_s3_reg) ? sleep_s3_reg
                                                    : sleep_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sleep_s1_reg <= 1'b0;
            sleep_s2_reg <= 1'b0;
            sleep_s3_reg <= 1'b0;
            sleep_reg    <= 1'b0;
        end
        else
        begin
            sleep_s1_reg <= sleep_request_i;
            sleep_s2_reg <= sleep_s1_reg;
            sleep_s3_reg <= sleep_s2_reg;
            sleep_reg    <= sleep_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access control

    // Sleep also masks edges, so nothing moves and the array is kept
    assign qualified = !clock_qualify_n_i && !sleep_reg;
    assign selected  = !chip_select1_n_i && chip_select2_i
                       && !chip_select3_n_i;

    // Strap is a static tie; it is taken while reset is held
    always_comb
    begin
        order_next = burst_mode_i ? sram_port_pkg::ORDER_INTERLEAVED
                                  : sram_port_pkg::ORDER_LINEAR;
    end

    always_comb
    begin
        access_next = access_reg;
        base_next   = base_reg;
        count_next  = count_reg;
        drive_next  = drive_reg;
        read_next   = read_reg;
        if (qualified)
        begin
            if (!advance_load_n_i)
            begin
                // Deselect only happens on a load edge
                if (selected)
                begin
                    base_next   = address_i;
                    count_next  = `SRAM_BURST_RST;
                    access_next = write_strobe_n_i
                                ? sram_port_pkg::ACC_READ
                                : sram_port_pkg::ACC_WRITE;
                end
                else
                begin
                    access_next = sram_port_pkg::ACC_IDLE;
                end
            end
            else
            begin
                case (access_reg)
                    sram_port_pkg::ACC_IDLE:
                        count_next = count_reg;
                    default:
                        count_next = count_reg + 1'b1;
                endcase
            end
            // Pins drive only for a read that did not follow a deselect
            drive_next = (access_next == sram_port_pkg::ACC_READ)
                      && (access_reg != sram_port_pkg::ACC_IDLE);
            if (access_next == sram_port_pkg::ACC_READ)
                read_next = mem_reg[burst_index(base_next, count_next,
                                                order_reg)];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            access_reg <= sram_port_pkg::ACC_IDLE;
            order_reg  <= order_next;
            base_reg   <= `SRAM_ADDR_RST;
            count_reg  <= `SRAM_BURST_RST;
            drive_reg  <= 1'b0;
            read_reg   <= `SRAM_DATA_RST;
        end
        else
        begin
            access_reg <= access_next;
            base_reg   <= base_next;
            count_reg  <= count_next;
            drive_reg  <= drive_next;
            read_reg   <= read_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write path: data follows its address by one qualified edge

    // Lanes and data are taken at the data edge of the write
    assign push_valid = qualified
                     && (access_reg == sram_port_pkg::ACC_WRITE);
    assign push_data  = {burst_index(base_reg, count_reg, order_reg),
                         byte_write_n_i, parity_lines_i, data_i};

    sync_fifo #(
        .WIDTH (`SRAM_FIFO_W),
        .DEPTH (`SRAM_FIFO_DEPTH)
    ) write_buffer (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (write_ready_o),
        .in_data_i   (push_data),
        .out_valid_o (drain_valid),
        .out_ready_i (drain_ready),
        .out_data_o  (drain_data)
    );

    // Array writes stop in sleep; buffered writes wait for the wake
    assign drain_ready  = !sleep_reg;
    assign drain_addr   = drain_data[`SRAM_FIFO_W-1 -: `SRAM_ADDR_W];
    assign drain_mask_n = drain_data[`SRAM_WORD_W +: `SRAM_LANES];
    assign drain_word   = drain_data[`SRAM_WORD_W-1:0];

    always_ff @(posedge clk_i)
    begin
        if (drain_valid && drain_ready)
        begin
            for (int k = 0; k < `SRAM_LANES; k++)
            begin
                if (!drain_mask_n[k])
                begin
                    mem_reg[drain_addr][k*`SRAM_LANE_W +: `SRAM_LANE_W]
                        <= drain_word[k*`SRAM_LANE_W +: `SRAM_LANE_W];
                    mem_reg[drain_addr][`SRAM_DATA_W + k]
                        <= drain_word[`SRAM_DATA_W + k];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pins

    // Enable is combinational so the async output enable acts at once
    assign data_oe_n_o    = !(drive_reg && !output_enable_n_i
                              && !sleep_reg);
    assign data_o         = read_reg[`SRAM_DATA_W-1:0];
    assign parity_lines_o = read_reg[`SRAM_WORD_W-1:`SRAM_DATA_W];

endmodule

// >>> sim/sram_port_asserts.sv
// Port assertions of the burst SRAM port
`include "sram_port_regs.svh"
module sram_port_checker (
    // Clock and reset
    input wire logic                    clk_i,
    input wire logic                    rst_n_i,
    // Control
    input wire logic                    write_strobe_n_i,
    input wire logic                    advance_load_n_i,
    input wire logic                    chip_select1_n_i,
    input wire logic                    chip_select2_i,
    input wire logic                    chip_select3_n_i,
    input wire logic                    clock_qualify_n_i,
    input wire logic                    output_enable_n_i,
    input wire logic                    sleep_request_i,
    // Outputs
    input wire logic [`SRAM_DATA_W-1:0] data_o,
    input wire logic [`SRAM_LANES-1:0]  parity_lines_o,
    input wire logic                    data_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Sleep lags by a few flops; the bench leaves a gap after it
    logic q;
    logic ld;
    logic sel;
    logic rd;
    assign q   = !clock_qualify_n_i && !sleep_request_i;
    assign ld  = q && !advance_load_n_i;
    assign sel = !chip_select1_n_i && chip_select2_i && !chip_select3_n_i;
    assign rd  = ld && sel && write_strobe_n_i;
    ////////////////////////////////////////////////////////////////////
    property p_hold;
        clock_qualify_n_i |=> $stable(data_o) && $stable(parity_lines_o);
    endproperty
    property p_oe_off;
        output_enable_n_i |-> data_oe_n_o;
    endproperty
    property p_desel;
        ld && !sel |=> data_oe_n_o;
    endproperty
    property p_wr;
        ld && sel && !write_strobe_n_i |=> data_oe_n_o;
    endproperty
    property p_first;
        ld && !sel ##1 rd |=> data_oe_n_o;
    endproperty
    property p_drive;
        rd ##1 (rd && !output_enable_n_i)
            |=> (output_enable_n_i || !data_oe_n_o);
    endproperty
    property p_adv_idle;
        ld && !sel ##1 (q && advance_load_n_i) |=> data_oe_n_o;
    endproperty
    property p_sleep;
        sleep_request_i [*5] |-> data_oe_n_o ##1 $stable(data_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved while clock held");
    a_oe_off: assert property (p_oe_off)
        else $error("pins driven with output enable high");
    a_desel: assert property (p_desel)
        else $error("pins driven after deselect");
    a_wr: assert property (p_wr)
        else $error("pins driven in write data phase");
    a_first: assert property (p_first)
        else $error("pins driven first clock out of deselect");
    a_drive: assert property (p_drive)
        else $error("read after read not driven");
    a_adv_idle: assert property (p_adv_idle)
        else $error("advance while idle drove pins");
    a_sleep: assert property (p_sleep)
        else $error("activity during sleep");
    c_read_pair: cover property (rd ##1 rd);
    c_write: cover property (ld && sel && !write_strobe_n_i);
    c_sleep: cover property (sleep_request_i [*5]);
endmodule

bind sync_burst_sram_port sram_port_checker sram_port_checker_inst (
    .clk_i, .rst_n_i, .write_strobe_n_i, .advance_load_n_i,
    .chip_select1_n_i, .chip_select2_i, .chip_select3_n_i,
    .clock_qualify_n_i, .output_enable_n_i, .sleep_request_i,
    .data_o, .parity_lines_o, .data_oe_n_o
);

// >>> sim/bus_master_model.sv
// Bus master model that drives the burst SRAM port
`include "sram_port_regs.svh"
module bus_master_model (
    // Clock
    input  wire logic                clk_i,
    // Address and control; selects are {one_n, two, three_n}
    output logic [`SRAM_ADDR_W-1:0]  address_o,
    output logic                     write_strobe_n_o,
    output logic [`SRAM_LANES-1:0]   byte_write_n_o,
    output logic                     advance_load_n_o,
    output logic [2:0]               chip_selects_o,
    output logic                     clock_qualify_n_o,
    // Write data, parity of lane k in bit 32+k
    output logic [`SRAM_WORD_W-1:0]  word_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        address_o = '0;
        write_strobe_n_o = 1'h1;
        byte_write_n_o = 4'hf;
        advance_load_n_o = 1'h0;
        chip_selects_o = 3'h7;
        clock_qualify_n_o = 1'h1;
        word_o = '0;
    end
    // One cycle: drive after the falling edge, hold past the rising one
    task automatic cyc(input logic qn, input logic ldn, input logic wen,
                       input logic [2:0] s,
                       input logic [`SRAM_ADDR_W-1:0] a,
                       input logic [3:0] bn, input logic [35:0] wd);
        @(negedge clk_i);
        clock_qualify_n_o = qn;
        advance_load_n_o = ldn;
        write_strobe_n_o = wen;
        chip_selects_o = s;
        address_o = a;
        byte_write_n_o = bn;
        // Released lines toggle so stale data never looks valid
        word_o = (&bn) ? ~word_o : wd;
        @(posedge clk_i);
        #1;
    endtask
endmodule

// >>> sim/tb.sv
// Self-checking testbench of the burst SRAM port
`include "sram_port_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0]  SEL = 3'h2;
    localparam logic [2:0]  DES = 3'h7;
    localparam logic [3:0]  NOB = 4'hf;
    localparam logic [18:0] B   = 19'h40100;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        oe_n = 1'h0;
    logic        sleep = 1'h0;
    logic        mode = 1'h0;
    logic [18:0] addr;
    logic        wstrobe_n;
    logic [3:0]  bw_n;
    logic        adv_n;
    logic [2:0]  cs;
    logic        qual_n;
    logic [35:0] word;
    logic [31:0] dout;
    logic [3:0]  pout;
    logic        oe_out;
    logic        wready;
    int          failures = 0;
    int          check_count = 0;
    always #25 clk = ~clk;
    bus_master_model bus_master_model_inst (.clk_i(clk), .address_o(addr),
        .write_strobe_n_o(wstrobe_n), .byte_write_n_o(bw_n),
        .advance_load_n_o(adv_n), .chip_selects_o(cs),
        .clock_qualify_n_o(qual_n), .word_o(word));
    sync_burst_sram_port sync_burst_sram_port_inst (.clk_i(clk),
        .rst_n_i(rst_n), .address_i(addr), .write_strobe_n_i(wstrobe_n),
        .byte_write_n_i(bw_n), .advance_load_n_i(adv_n),
        .chip_select1_n_i(cs[2]), .chip_select2_i(cs[1]),
        .chip_select3_n_i(cs[0]), .clock_qualify_n_i(qual_n),
        .output_enable_n_i(oe_n), .sleep_request_i(sleep),
        .burst_mode_i(mode), .data_i(word[31:0]),
        .parity_lines_i(word[35:32]), .data_o(dout),
        .parity_lines_o(pout), .data_oe_n_o(oe_out),
        .write_ready_o(wready));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic go(input logic qn, input logic ldn, input logic wen,
                      input logic [2:0] s, input logic [18:0] a,
                      input logic [3:0] bn, input logic [35:0] wd);
        bus_master_model_inst.cyc(qn, ldn, wen, s, a, bn, wd);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_write_read();
        go(0, 0, 0, SEL, B, NOB, '0);
        go(0, 0, 1, DES, B, 4'h0, 36'ha11223344);
        go(0, 0, 0, SEL, B, NOB, '0);
        go(0, 0, 1, DES, B, 4'h1, 36'h5aabbccdd);
        repeat (4) go(0, 0, 1, DES, B, NOB, '0);
        go(0, 0, 1, SEL, B, NOB, '0);
        check({35'h0, oe_out}, 36'h1);
        check({pout, dout}, 36'h4aabbcc44);
        go(0, 0, 1, SEL, B, NOB, '0);
        check({35'h0, oe_out}, 36'h0);
        check({35'h0, wready}, 36'h1);
        @(negedge clk) oe_n = 1'h1;
        #1 check({35'h0, oe_out}, 36'h1);
        @(negedge clk) oe_n = 1'h0;
        $display("write_read done");
    endtask
    task automatic t_burst();
        go(0, 0, 0, SEL, B + 19'h1, NOB, '0);
        for (int i = 0; i < 4; i++)
            go(0, i < 3, 1, i < 3 ? SEL : DES, B, 4'h0,
               36'h3d0000000 + 36'(i));
        repeat (4) go(0, 0, 1, DES, B, NOB, '0);
        @(negedge clk) rst_n = 1'h0;
        mode = 1'h1;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        for (int k = 0; k < 4; k++)
        begin
            go(0, k > 0, 1, SEL, B + 19'h1, NOB, '0);
            check({pout, dout}, 36'h3d0000000 + 36'(((1 ^ k) + 3) % 4));
            check({35'h0, oe_out}, {35'h0, k == 0});
            if (k == 1)
            begin
                repeat (2) go(1, 0, 0, SEL, 19'h0, 4'h0, '0);
                check({pout, dout}, 36'h3d0000003);
            end
        end
        $display("burst done");
    endtask
    task automatic t_selects();
        for (int s = 0; s < 8; s++)
        begin
            go(0, 0, 1, SEL, B, NOB, '0);
            go(0, 0, 1, 3'(s), B, NOB, '0);
            check({35'h0, oe_out}, {35'h0, s != 2});
        end
        go(0, 1, 1, SEL, B, NOB, '0);
        check({35'h0, oe_out}, 36'h1);
        $display("selects done");
    endtask
    task automatic t_sleep();
        @(negedge clk) sleep = 1'h1;
        repeat (5) go(1, 0, 1, DES, B, NOB, '0);
        go(0, 0, 0, SEL, B + 19'h1, NOB, '0);
        go(0, 0, 1, DES, B, 4'h0, '0);
        check({35'h0, oe_out}, 36'h1);
        @(negedge clk) sleep = 1'h0;
        repeat (6) go(1, 0, 1, DES, B, NOB, '0);
        repeat (2) go(0, 0, 1, SEL, B + 19'h1, NOB, '0);
        check({pout, dout}, 36'h3d0000000);
        $display("sleep done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        #50us;
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        t_write_read();
        t_burst();
        t_selects();
        t_sleep();
        stop_test();
    end
endmodule
